// ==== rtl/ucv_core.sv ====
// ULPI command decode, RXCMD generation and VBUS power control
// Notes on behaviour
// - Both supply bits clear: pump and external switch both off.
// - Pump bit alone set: internal charge pump on.
// - External bit set: drive open-drain switch output low regardless of pump bit.
// - Fault pin is looked at only while monitor enable is set.
// - Fault is active low, inverted to active high by the invert bit.
// - Nonzero byte starts a command; NXT marks acceptance before further bytes.
// - Top two bits give command type; low six are payload.
// - Transmit with zero payload sends PID-less data after next byte.
// - Transmit payload 00xxxx carries packet identifier in low four bits.
// - Payload 101111 on read/write takes a full address byte next.
// - Other read/write payloads are the immediate six-bit address.
// - Status goes out with DIR high and an RXCMD byte.
// - Any RXCMD field change sends a fresh RXCMD.
// - A change that reverts before it is sent may be skipped.
// - RXCMD: line 1:0, vbus 3:2, event 5:4, id 6, alt 7.
// - Enabled B-session edges send an RXCMD with bit 7 set.
// - A data-line change sends the new line condition.
// - Peripheral line encoding per speed select and termination.
// - Host line encoding, low-speed swaps J and K.
// - With DIR high NXT stays low except for data, bus carries RXCMD.
// - DIR during a register operation aborts it; link retries. Here status waits for idle, so no operation is aborted.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
module ucv_core #(
    parameter int REG_DEPTH = 256
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // ULPI link side (link clock sampled as data)
    input  wire logic        link_clk,
    input  wire logic [7:0]  ulpi_data_in,
    input  wire logic        ulpi_stp,
    output logic      [7:0]  ulpi_data_out,
    output logic             ulpi_data_oe,
    output logic             ulpi_dir,
    output logic             ulpi_nxt,
    // Analog front-end status
    input  wire logic        line_dp,
    input  wire logic        line_dm,
    input  wire logic        squelch,
    input  wire logic        hs_diff,
    input  wire logic [1:0]  vbus_state,
    input  wire logic [1:0]  rx_event,
    input  wire logic        id_pin,
    input  wire logic        bsess_valid,
    input  wire logic        fault_pin,
    // Power and transmit outputs
    output logic             internal_pump_enable,
    output logic             supply_switch_out_low,
    output logic             supply_switch_oe,
    output logic             vbus_fault,
    output logic             tx_start,
    output logic             tx_transmit_without_pid,
    output logic      [3:0]  tx_pid
);
    initial begin
        if (REG_DEPTH != 256) $error("ucv_core: REG_DEPTH must be 256");
    end

    // ------------------------------------------------------------
    // Synchronisers for pins
    // ------------------------------------------------------------
    localparam int NSYNC = 18;
    logic [NSYNC-1:0] s1_q, s2_q;
    wire  [NSYNC-1:0] s_in = {link_clk, ulpi_stp, ulpi_data_in, line_dp, line_dm, squelch,
                              hs_diff, id_pin, bsess_valid, fault_pin, 1'b0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s_in;
            s2_q <= s1_q;
        end
    end
    logic [1:0] vb1_q, vb2_q, ev1_q, ev2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vb1_q <= '0;
            vb2_q <= '0;
            ev1_q <= '0;
            ev2_q <= '0;
        end else begin
            vb1_q <= vbus_state;
            vb2_q <= vb1_q;
            ev1_q <= rx_event;
            ev2_q <= ev1_q;
        end
    end
    wire       lclk_s  = s2_q[17];
    wire [7:0] data_s  = s2_q[15:8];
    wire       dp_s    = s2_q[7];
    wire       dm_s    = s2_q[6];
    wire       sq_s    = s2_q[5];
    wire       hsd_s   = s2_q[4];
    wire       id_s    = s2_q[3];
    wire       bval_s  = s2_q[2];
    wire       fault_s = s2_q[1];

    logic lclk_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lclk_prev_q <= 1'b0;
        else          lclk_prev_q <= lclk_s;
    end
    wire lrise = lclk_s & ~lclk_prev_q;

    // ------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [6:0] phy_q;
    ucv_pkg::ucv_cmd_s last_cmd_q;
    logic [7:0] regs_q [REG_DEPTH];
    wire apb_wr  = psel & penable & pwrite;
    wire sel_ctl = paddr == ucv_pkg::OFF_CTRL;
    wire sel_phy = paddr == ucv_pkg::OFF_PHY;
    wire sel_st  = paddr == ucv_pkg::OFF_STATUS;
    wire sel_lc  = paddr == ucv_pkg::OFF_LASTCMD;
    wire mapped  = sel_ctl | sel_phy | sel_st | sel_lc;
    ucv_pkg::ucv_rxcmd_s rx_now;
    ucv_pkg::ucv_state_e st_q;
    wire [31:0] rd_mux = sel_ctl ? {26'h0, ctrl_q} :
                         sel_phy ? {25'h0, phy_q} :
                         sel_st  ? {22'h0, vbus_fault, ulpi_dir, rx_now} :
                         sel_lc  ? {20'h0, last_cmd_q} : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= ucv_pkg::CTRL_RST;
            phy_q   <= ucv_pkg::PHY_RST;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~pready;
            pslverr <= psel & ~pready & ~mapped;
            prdata  <= rd_mux;
            if (apb_wr & pready & sel_ctl) ctrl_q <= pwdata[5:0];
            if (apb_wr & pready & sel_phy) phy_q  <= pwdata[6:0];
        end
    end

    // ------------------------------------------------------------
    // VBUS power and fault
    // ------------------------------------------------------------
    // Pump only when its bit alone set
    wire pump_d = ctrl_q[ucv_pkg::CTRL_PUMP] & ~ctrl_q[ucv_pkg::CTRL_EXT];
    wire fault_d = ctrl_q[ucv_pkg::CTRL_MON] & (fault_s ^ ~ctrl_q[ucv_pkg::CTRL_INV]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_pump_enable  <= 1'b0;
            supply_switch_out_low <= 1'b0;
            supply_switch_oe      <= 1'b0;
            vbus_fault            <= 1'b0;
        end else begin
            internal_pump_enable  <= pump_d;
            // Open drain pulled low when external on
            supply_switch_out_low <= 1'b0;
            supply_switch_oe      <= ctrl_q[ucv_pkg::CTRL_EXT];
            vbus_fault            <= fault_d;
        end
    end

    // ------------------------------------------------------------
    // Line condition and RXCMD content
    // ------------------------------------------------------------
    wire [1:0] xs   = phy_q[ucv_pkg::PHY_XS +: 2];
    wire       term = phy_q[ucv_pkg::PHY_TERM];
    wire [1:0] opk  = phy_q[ucv_pkg::PHY_OPK +: 2];
    wire       host = phy_q[ucv_pkg::PHY_DPPD] & phy_q[ucv_pkg::PHY_DMPD];
    wire [1:0] fs_ls = {dm_s, dp_s};
    wire [1:0] hs_ls = {1'b0, ~sq_s};
    wire [1:0] ch_ls = sq_s ? 2'h0 : (hsd_s ? 2'h1 : 2'h2);
    // Host chirp only with operating kind 10
    wire       chirp = host ? (~term & (opk == 2'h2)) : term;
    // Low speed only renames J and K; the raw line pair is reported
    wire [1:0] line_d = (xs != 2'h0) ? fs_ls :
                        chirp ? ch_ls : hs_ls;
    logic bval_prev_q, alt_q;
    // Enabled B-session edges raise alternate flag
    wire b_edge = (bval_s & ~bval_prev_q & ctrl_q[ucv_pkg::CTRL_BRISE]) |
                  (~bval_s & bval_prev_q & ctrl_q[ucv_pkg::CTRL_BFALL]);
    assign rx_now = '{alt: alt_q | b_edge, id: id_s, rx_event: ev2_q, vbus: vb2_q, line: line_d};
    ucv_pkg::ucv_rxcmd_s sent_q;
    // Pending while current differs from last sent
    wire pend = (rx_now != sent_q);

    // ------------------------------------------------------------
    // Command engine
    // ------------------------------------------------------------
    wire [1:0] ctype   = data_s[7:6];
    wire [5:0] payload = data_s[5:0];
    logic [7:0] waddr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q          <= ucv_pkg::ST_IDLE;
            ulpi_dir      <= 1'b0;
            ulpi_nxt      <= 1'b0;
            ulpi_data_out <= ucv_pkg::IDLE_BYTE;
            ulpi_data_oe  <= 1'b0;
            sent_q        <= '0;
            alt_q         <= 1'b0;
            bval_prev_q   <= 1'b0;
            last_cmd_q    <= '0;
            waddr_q       <= 8'h00;
            tx_start      <= 1'b0;
            tx_transmit_without_pid      <= 1'b0;
            tx_pid        <= 4'h0;
        end else begin
            bval_prev_q <= bval_s;
            if (b_edge) alt_q <= 1'b1;
            tx_start <= 1'b0;
            if (lrise) begin
                case (st_q)
                    ucv_pkg::ST_IDLE: begin
                        ulpi_nxt <= 1'b0;
                        // Status takes priority over a new command
                        // Status only between operations, so none is cut short
                        if (pend) begin
                            ulpi_dir      <= 1'b1;
                            ulpi_data_oe  <= 1'b0;
                            st_q          <= ucv_pkg::ST_TURN;
                        end else if (data_s != ucv_pkg::IDLE_BYTE) begin
                            last_cmd_q.kind  <= ctype;
                            last_cmd_q.ext   <= ctype[1] & (payload == ucv_pkg::PAYLOAD_EXT);
                            last_cmd_q.transmit_without_pid <= (ctype == ucv_pkg::CT_TX) & (payload == 6'h00);
                            last_cmd_q.addr  <= {2'h0, payload};
                            waddr_q          <= {2'h0, payload};
                            ulpi_nxt         <= 1'b1;
                            st_q             <= ucv_pkg::ST_ACCEPT;
                            if (ctype == ucv_pkg::CT_TX) begin
                                tx_pid   <= payload[3:0];
                                tx_transmit_without_pid <= payload == 6'h00;
                            end
                        end
                    end
                    ucv_pkg::ST_ACCEPT: begin
                        ulpi_nxt <= 1'b0;
                        // Take the data byte before transmitting
                        if (last_cmd_q.kind == ucv_pkg::CT_TX) begin
                            ulpi_nxt <= 1'b1;
                            st_q     <= ucv_pkg::ST_DATA;
                        end else if (last_cmd_q.ext) begin
                            ulpi_nxt <= 1'b1;
                            st_q     <= ucv_pkg::ST_ADDR;
                        end else if (last_cmd_q.kind == ucv_pkg::CT_WRITE) begin
                            ulpi_nxt <= 1'b1;
                            st_q     <= ucv_pkg::ST_DATA;
                        end else begin
                            ulpi_dir <= 1'b1;
                            st_q     <= ucv_pkg::ST_RDDATA;
                        end
                    end
                    ucv_pkg::ST_ADDR: begin
                        waddr_q         <= data_s;
                        last_cmd_q.addr <= data_s;
                        ulpi_nxt        <= last_cmd_q.kind == ucv_pkg::CT_WRITE;
                        ulpi_dir        <= last_cmd_q.kind == ucv_pkg::CT_READ;
                        st_q            <= (last_cmd_q.kind == ucv_pkg::CT_WRITE) ?
                                           ucv_pkg::ST_DATA : ucv_pkg::ST_RDDATA;
                    end
                    ucv_pkg::ST_DATA: begin
                        // Transmit starts once the byte is taken; a nonzero byte left on the bus starts a new command
                        if (last_cmd_q.kind == ucv_pkg::CT_TX) tx_start <= 1'b1;
                        else                                   regs_q[waddr_q] <= data_s;
                        ulpi_nxt        <= 1'b0;
                        st_q            <= ucv_pkg::ST_IDLE;
                    end
                    ucv_pkg::ST_RDDATA: begin
                        ulpi_nxt      <= 1'b0;
                        ulpi_data_out <= regs_q[waddr_q];
                        ulpi_data_oe  <= 1'b1;
                        st_q          <= ucv_pkg::ST_RXCMD;
                    end
                    ucv_pkg::ST_TURN: begin
                        // Send snapshot and clear alternate flag
                        ulpi_data_out <= rx_now;
                        ulpi_data_oe  <= 1'b1;
                        sent_q        <= '{alt: 1'b0, id: rx_now.id, rx_event: rx_now.rx_event,
                                           vbus: rx_now.vbus, line: rx_now.line};
                        alt_q         <= b_edge;
                        st_q          <= ucv_pkg::ST_RXCMD;
                    end
                    ucv_pkg::ST_RXCMD: begin
                        ulpi_data_oe <= 1'b0;
                        ulpi_dir     <= 1'b0;
                        st_q         <= ucv_pkg::ST_IDLE;
                    end
                    default: st_q <= ucv_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_pump_off_both: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ctrl_q[1:0]) == 2'b00 |-> !internal_pump_enable && !supply_switch_oe)
        else $error("supply active with both bits clear");
    chk_pump_alone_on: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ctrl_q[1:0]) == 2'b01 |-> internal_pump_enable)
        else $error("pump not enabled");
    chk_ext_switch_low: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ctrl_q[ucv_pkg::CTRL_EXT]) |-> supply_switch_oe && !supply_switch_out_low)
        else $error("external switch not driven low");
    chk_fault_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(ctrl_q[ucv_pkg::CTRL_MON]) |-> !vbus_fault)
        else $error("fault reported while monitor off");
    chk_fault_polarity: assert property (@(posedge pclk) disable iff (!presetn)
        $past(ctrl_q[ucv_pkg::CTRL_MON]) |-> vbus_fault == ($past(fault_s) ^ !$past(ctrl_q[ucv_pkg::CTRL_INV])))
        else $error("fault polarity wrong");
    chk_nxt_on_accept: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == ucv_pkg::ST_ACCEPT) |-> ulpi_nxt && !ulpi_dir)
        else $error("command accepted without NXT");
    chk_rxcmd_dir: assert property (@(posedge pclk) disable iff (!presetn)
        ulpi_data_oe |-> ulpi_dir)
        else $error("data driven without DIR");
    chk_dir_nxt_low: assert property (@(posedge pclk) disable iff (!presetn)
        ulpi_dir && ulpi_data_oe |-> !ulpi_nxt)
        else $error("NXT high during RXCMD");
    chk_transmit_without_pid_flag: assert property (@(posedge pclk) disable iff (!presetn)
        tx_start && tx_transmit_without_pid |-> tx_pid == 4'h0)
        else $error("PID-less transmit with nonzero PID");
endmodule

// ==== rtl/ucv_pkg.sv ====
// Package: constants and carrier types for the ULPI command and VBUS control block
package ucv_pkg;
    // ------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PHY     = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_LASTCMD = 8'h0c;
    // CTRL fields
    localparam int CTRL_PUMP  = 0;
    localparam int CTRL_EXT   = 1;
    localparam int CTRL_MON   = 2;
    localparam int CTRL_INV   = 3;
    localparam int CTRL_BRISE = 4;
    localparam int CTRL_BFALL = 5;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // PHY fields: [1:0] speed select, [2] termination, [4:3] operating kind, [5] dp pd, [6] dm pd
    localparam int PHY_XS   = 0;
    localparam int PHY_TERM = 2;
    localparam int PHY_OPK  = 3;
    localparam int PHY_DPPD = 5;
    localparam int PHY_DMPD = 6;
    localparam logic [6:0] PHY_RST = 7'h01;
    // ------------------------------------------------------------
    // Command encodings
    // ------------------------------------------------------------
    localparam logic [1:0] CT_IDLE  = 2'h0;
    localparam logic [1:0] CT_TX    = 2'h1;
    localparam logic [1:0] CT_WRITE = 2'h2;
    localparam logic [1:0] CT_READ  = 2'h3;
    localparam logic [5:0] PAYLOAD_EXT = 6'h2f;
    localparam logic [7:0] IDLE_BYTE   = 8'h00;

    typedef enum {
        ST_IDLE, ST_ACCEPT, ST_ADDR, ST_DATA, ST_TURN, ST_RDDATA, ST_RXCMD
    } ucv_state_e;

    typedef struct packed {
        logic       alt;
        logic       id;
        logic [1:0] rx_event;
        logic [1:0] vbus;
        logic [1:0] line;
    } ucv_rxcmd_s;

    typedef struct packed {
        logic [1:0] kind;
        logic       ext;
        logic       transmit_without_pid;
        logic [7:0] addr;
    } ucv_cmd_s;
endpackage

// ==== sim/ucv_link_model.sv ====
// Link controller model: drives the ULPI bus, collects RXCMD and read bytes
`timescale 1ns/1ns
module ucv_link_model (
    // Link clock and drive
    output logic       link_clk,
    output logic [7:0] link_d,
    output logic       link_stp,
    // Device side
    input  wire logic       dir,
    input  wire logic       nxt,
    input  wire logic [7:0] dev_d
);
    logic [7:0] rx_last = 8'h00;
    logic [7:0] rd_byte = 8'h00;
    logic       alt_seen = 1'b0;
    logic       grab = 1'b0;
    logic       dir_prev = 1'b0;
    // ------------------------------------------------------------
    // Clock runs free, as the transceiver clock does once stable
    // ------------------------------------------------------------
    // Idle value by default
    initial begin
        link_d   = 8'h00;
        link_stp = 1'b0;
        link_clk = 1'b0;
        // Offset keeps link edges clear of pclk edges
        #2;
        forever begin
            #62 link_clk = 1'b1;
            #63 link_clk = 1'b0;
        end
    end
    // Any byte after a turn is taken, single or back to back
    always @(posedge link_clk) begin
        if (dir && dir_prev && grab) begin
            rd_byte <= dev_d;
            grab    <= 1'b0;
        end else if (dir && dir_prev) begin
            rx_last  <= dev_d;
            alt_seen <= alt_seen | dev_d[7];
        end
        dir_prev <= dir;
    end
    // Hold each byte until NXT; a status turn in between is retried
    task automatic put(input logic [7:0] b);
        int n;
        @(negedge link_clk);
        link_d = b;
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (nxt !== 1'b1 && n < 40);
    endtask
    task automatic stop();
        @(negedge link_clk);
        link_d   = 8'h00;
        link_stp = 1'b1;
        @(negedge link_clk);
        link_stp = 1'b0;
    endtask
    // Only defined codes; full address follows the extended code
    task automatic reg_wr(input logic [7:0] a, input logic ext, input logic [7:0] d);
        put(ext ? 8'haf : {2'b10, a[5:0]});
        if (ext) put(a);
        put(d);
        stop();
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic ext, output logic [7:0] d);
        int n;
        put(ext ? 8'hef : {2'b11, a[5:0]});
        if (ext) put(a);
        @(negedge link_clk);
        link_d = 8'h00;
        grab   = 1'b1;
        n = 0;
        while (grab && n < 40) begin
            @(posedge link_clk);
            n++;
        end
        d = rd_byte;
    endtask
    task automatic tx(input logic [7:0] c, input logic [7:0] d);
        put(c);
        put(d);
        stop();
    endtask
endmodule

// ==== sim/ucv_core_tb.sv ====
// Testbench: APB and ULPI traffic against the command and VBUS control block
`timescale 1ns/1ns
module ucv_core_tb;
    logic        pclk, pready, pslverr, link_clk, ulpi_stp, ulpi_data_oe, ulpi_dir, ulpi_nxt;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, link_d, ulpi_data_in, ulpi_data_out, b;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        line_dp = 1'b0, line_dm = 1'b0, squelch = 1'b1, hs_diff = 1'b0, id_pin = 1'b1;
    logic [1:0]  vbus_state = 2'h2, rx_event = 2'h1;
    logic        bsess_valid = 1'b0, fault_pin = 1'b1, er;
    logic        pump_en, sw_low, sw_oe, vbus_fault, tx_start, tx_transmit_without_pid;
    logic [3:0]  tx_pid;
    int          err_total = 0, n_checks = 0, tx_cnt = 0, n;
    logic [6:0]  phy_t [7] = '{7'h05, 7'h05, 7'h00, 7'h04, 7'h66, 7'h60, 7'h70};
    logic [3:0]  fe_t  [7] = '{4'ha, 4'h6, 4'h4, 4'h4, 4'ha, 4'ha, 4'h9};
    logic [1:0]  ln_t  [7] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h1};
    logic [7:0]  ra_t  [2] = '{8'h15, 8'hc3};
    logic [7:0]  rv_t  [2] = '{8'ha5, 8'h3c};
    logic [7:0]  tc_t  [2] = '{8'h43, 8'h40};
    // ------------------------------------------------------------
    // Device, link model and the shared data wire
    // ------------------------------------------------------------
    ucv_core i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
        .ulpi_data_in(ulpi_data_in), .ulpi_stp(ulpi_stp), .ulpi_data_out(ulpi_data_out),
        .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .line_dp(line_dp),
        .line_dm(line_dm), .squelch(squelch), .hs_diff(hs_diff), .vbus_state(vbus_state),
        .rx_event(rx_event), .id_pin(id_pin), .bsess_valid(bsess_valid), .fault_pin(fault_pin),
        .internal_pump_enable(pump_en), .supply_switch_out_low(sw_low), .supply_switch_oe(sw_oe),
        .vbus_fault(vbus_fault), .tx_start(tx_start), .tx_transmit_without_pid(tx_transmit_without_pid), .tx_pid(tx_pid));
    ucv_link_model i_link (.link_clk(link_clk), .link_d(link_d), .link_stp(ulpi_stp), .dir(ulpi_dir),
        .nxt(ulpi_nxt), .dev_d(ulpi_data_out));
    // A released bus must not look like the last driven value
    assign ulpi_data_in = ulpi_data_oe ? ulpi_data_out : (ulpi_dir ? ~link_d : link_d);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (tx_start === 1'b1) tx_cnt <= tx_cnt + 1;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Slow link traffic dominates; well above the expected run
    initial begin
        #500000;
        err_total++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ucv_pkg::OFF_CTRL, 32'h0);
        chk(rd, {26'h0, ucv_pkg::CTRL_RST});
        apb(1'b0, ucv_pkg::OFF_PHY, 32'h0);
        chk(rd, {25'h0, ucv_pkg::PHY_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ucv_pkg::OFF_CTRL, i);
            repeat (2) @(posedge pclk);
            chk(sw_oe, i[1]);
            chk(sw_low, 1'b0);
            if (i[1] == 1'b0) chk(pump_en, i[0]);
        end
        for (int i = 0; i < 8; i++) begin
            fault_pin <= i[2];
            apb(1'b1, ucv_pkg::OFF_CTRL, {28'h0, i[1], i[0], 2'b00});
            repeat (6) @(posedge pclk);
            chk(vbus_fault, i[0] & (i[1] ? i[2] : ~i[2]));
        end
        for (int i = 0; i < 7; i++) begin
            {line_dp, line_dm, squelch, hs_diff} <= fe_t[i];
            apb(1'b1, ucv_pkg::OFF_PHY, {25'h0, phy_t[i]});
            b = {2'b01, 2'h1, 2'h2, ln_t[i]};
            n = 0;
            while (i_link.rx_last !== b && n < 400) begin
                @(posedge pclk);
                n++;
            end
            chk(i_link.rx_last, b);
            apb(1'b0, ucv_pkg::OFF_STATUS, 32'h0);
            chk(rd[7:0], b);
        end
        bsess_valid <= 1'b1;
        repeat (60) @(posedge pclk);
        bsess_valid <= 1'b0;
        repeat (60) @(posedge pclk);
        chk(i_link.alt_seen, 1'b0);
        apb(1'b1, ucv_pkg::OFF_CTRL, 32'h10);
        bsess_valid <= 1'b1;
        n = 0;
        while (i_link.alt_seen !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(i_link.alt_seen, 1'b1);
        for (int i = 0; i < 2; i++) begin
            i_link.reg_wr(ra_t[i], i[0], rv_t[i]);
            i_link.reg_rd(ra_t[i], i[0], b);
            chk(b, rv_t[i]);
            apb(1'b0, ucv_pkg::OFF_LASTCMD, 32'h0);
            chk(rd[11:0], {ucv_pkg::CT_READ, i[0], 1'b0, ra_t[i]});
        end
        for (int i = 0; i < 2; i++) begin
            n = tx_cnt;
            i_link.tx(tc_t[i], 8'hc3);
            chk(tx_cnt - n, 32'h1);
            chk(tx_transmit_without_pid, i[0]);
            chk(tx_pid, tc_t[i][3:0]);
            apb(1'b0, ucv_pkg::OFF_LASTCMD, 32'h0);
            chk(rd[11:8], {ucv_pkg::CT_TX, 1'b0, i[0]});
        end
        complete_run();
    end
endmodule
